// ### tb_top.sv
// self-checking bench joining controller and device over the link
`timescale 1ns/1ps
`include "tcd_cfg.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
  import tcd_pkg::*;
;
  logic                   clk_i, resetn_i, req_i, wake_i, free_strobe_i, busy_o, read_seen_o;
  logic                   write_reserved_o, powered_down_o, self_refresh_o;
  logic [2:0]             req_op_i, op_o, seen_op;
  logic [1:0]             req_bank_i, req_vw_i, op_bank_o;
  logic [13:0]            req_upper_i, op_upper_o;
  logic [6:0]             req_lower_i, op_lower_o;
  logic [3:0]             write_mask_o;
  logic [15:0]            mode_code_o;
  logic [`TCD_DQ_W-1:0]   rd_data_i;
  int                     n_errors, comparisons;
  logic                   got_read, got_stb;
  logic [`TCD_DQ_W-1:0]   got_dq;
  tcd_link_if link ();
  tcd_controller tcd_controller_i (.clk_i(clk_i), .resetn_i(resetn_i), .link(link), .req_i(req_i),
    .req_op_i(req_op_i), .req_bank_i(req_bank_i), .req_upper_i(req_upper_i), .req_lower_i(req_lower_i),
    .req_vw_i(req_vw_i), .wake_i(wake_i), .busy_o(busy_o), .read_seen_o(read_seen_o));
  tcd_device #(.BURST_LEN(4)) tcd_device_i (.link(link), .free_strobe_i(free_strobe_i), .rd_data_i(rd_data_i),
    .op_o(op_o), .op_bank_o(op_bank_o), .op_upper_o(op_upper_o), .op_lower_o(op_lower_o),
    .write_mask_o(write_mask_o), .write_reserved_o(write_reserved_o), .mode_code_o(mode_code_o),
    .powered_down_o(powered_down_o), .self_refresh_o(self_refresh_o));
  tcd_link_monitor tcd_link_monitor_i (.link_clk(link.link_clk), .resetn_i(resetn_i),
    .free_strobe_i(free_strobe_i), .chip_select_n(link.chip_select_n), .function_select(link.function_select),
    .powerdown_pin_n(link.powerdown_pin_n), .dq_oe(link.dq_oe), .lower_read_strobe(link.lower_read_strobe),
    .upper_read_strobe(link.upper_read_strobe));
  // system clock, 25 ns period
  always #12.5 clk_i = ~clk_i;
  // remember the last operation pulse of the device
  always @(posedge link.link_clk) if (^op_o !== 1'bx && op_o != 3'h0) seen_op <= op_o;
  // read traffic stands only briefly, so keep sticky copies of it
  always @(posedge clk_i) begin
    if (read_seen_o === 1'b1) got_read <= 1'b1;
    if (link.dq_oe === 1'b1) got_dq <= link.dq;
    if (link.dq_oe === 1'b1 && link.upper_read_strobe === 1'b1) got_stb <= 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic give_verdict();
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one request pulse, then a bounded wait for the controller to finish
  task automatic issue(input logic [2:0] op, input logic [1:0] vw, input bit wait_done);
    int k;
    seen_op = 3'h0;
    got_read = 1'b0;
    got_stb = 1'b0;
    got_dq = '0;
    req_op_i = op;
    req_vw_i = vw;
    req_i = 1'b1;
    cyc(1);
    req_i = 1'b0;
    k = 0;
    while (wait_done && busy_o !== 1'b0 && k < 400) begin cyc(1); k++; end
    `CHK(k < 400, 1'b1)
    cyc(24);
  endtask
  task automatic t_read();
    issue(TCD_OP_READ, 2'h0, 1);
    `CHK(seen_op, TCD_OP_READ)
    `CHK(op_bank_o, 2'h2)
    `CHK(op_upper_o, 14'h1a5c)
    `CHK(op_lower_o, 7'h35)
    `CHK(got_read, 1'b1)
    `CHK(got_dq, rd_data_i)
    `CHK(got_stb, 1'b1)
  endtask
  // every length code, reserved one first so its flag must clear again
  task automatic t_write();
    logic [1:0] vw [4];
    logic [3:0] mk [4];
    vw = '{2'h0, 2'h2, 2'h1, 2'h3};
    mk = '{4'h0, 4'hf, 4'h3, 4'h1};
    for (int i = 0; i < 4; i++) begin
      issue(TCD_OP_WRITE, vw[i], 1);
      `CHK(write_reserved_o, (i == 0))
      `CHK(got_read, 1'b0)
      if (i != 0) begin
        `CHK(seen_op, TCD_OP_WRITE)
        `CHK(write_mask_o, mk[i])
      end
    end
  endtask
  task automatic t_pair(input logic [2:0] op);
    issue(op, 2'h0, 1);
    `CHK(seen_op, op)
    `CHK(got_read, 1'b0)
    if (op == TCD_OP_MODE_SET) `CHK(mode_code_o, {2'h2, 14'h1a5c})
  endtask
  // sleep, then wake through the pin with select high
  task automatic t_sleep(input logic [2:0] op, input logic self);
    issue(op, 2'h0, 0);
    cyc(16);
    `CHK(link.powerdown_pin_n, 1'b0)
    `CHK(powered_down_o, 1'b1)
    `CHK(self_refresh_o, self)
    wake_i = 1'b1;
    cyc(30);
    `CHK(powered_down_o, 1'b0)
    `CHK(self_refresh_o, 1'b0)
    wake_i = 1'b0;
    cyc(30);
  endtask
  initial begin
    clk_i = 0; resetn_i = 0; req_i = 0; wake_i = 0; free_strobe_i = 0; req_op_i = 0; req_vw_i = 0;
    req_bank_i = 2'h2; req_upper_i = 14'h1a5c; req_lower_i = 7'h35; rd_data_i = 36'h9a5c33c5a;
    seen_op = 0; n_errors = 0; comparisons = 0; got_read = 0; got_stb = 0; got_dq = '0;
    cyc(5);
    resetn_i = 1;
    cyc(40);
    t_read();
    t_write();
    t_pair(TCD_OP_REFRESH);
    t_pair(TCD_OP_MODE_SET);
    t_sleep(TCD_OP_NONE, 1'b0);
    t_sleep(TCD_OP_SELF_REFRESH, 1'b1);
    free_strobe_i = 1;
    t_read();
    give_verdict();
  end
  // watchdog against a hang
  initial begin
    #1000000;
    n_errors++;
    give_verdict();
  end
endmodule

// ### tcd_cfg.svh
// constants for the two-cycle command decoder
`ifndef TCD_CFG_SVH
`define TCD_CFG_SVH
`define TCD_BA_W        2
`define TCD_ADDR_W      14
`define TCD_DQ_W        36
`define TCD_LANE_W      18
`define TCD_LA_W        7
`define TCD_VW0_BIT     13
`define TCD_VW1_BIT     12
`define TCD_DIV_HALF    4'h1
`define TCD_REF_GAP     5'h10
`endif

// ### tcd_controller.sv
// controller end issuing two-cycle command pairs
`timescale 1ns/1ps
`include "tcd_cfg.svh"
module tcd_controller
  import tcd_pkg::*;
(
  input  wire logic                    clk_i,       // system clock
  input  wire logic                    resetn_i,    // sync reset, active low
  tcd_link_if.ctrl                     link,        // link pins
  input  wire logic                    req_i,       // issue operation pulse
  input  wire logic [2:0]              req_op_i,    // tcd_op_t code
  input  wire logic [`TCD_BA_W-1:0]    req_bank_i,  // bank / mode bank bits
  input  wire logic [`TCD_ADDR_W-1:0]  req_upper_i, // upper address / op-code
  input  wire logic [`TCD_LA_W-1:0]    req_lower_i, // lower address
  input  wire logic [1:0]              req_vw_i,    // {vw0, vw1}
  input  wire logic                    wake_i,      // leave low power
  output logic                         busy_o,      // command in progress
  output logic                         read_seen_o  // read data observed
);
  typedef enum logic [2:0] {
    CS_IDLE,
    CS_SECOND,
    CS_PDWAIT,
    CS_LOWPWR,
    CS_REFGAP
  } tcd_cstate_t;
  tcd_cstate_t            st_q;
  tcd_cstate_t            st_d;
  tcd_op_t                op_q;
  tcd_op_t                op_d;
  logic [3:0]             div_q;
  logic [3:0]             div_d;
  logic                   lclk_q;
  logic                   lclk_d;
  logic                   edge_d;
  logic                   csn_q;
  logic                   csn_d;
  logic                   fn_q;
  logic                   fn_d;
  logic                   pdn_q;
  logic                   pdn_d;
  logic [`TCD_BA_W-1:0]   ba_q;
  logic [`TCD_BA_W-1:0]   ba_d;
  logic [`TCD_ADDR_W-1:0] a_q;
  logic [`TCD_ADDR_W-1:0] a_d;
  logic [`TCD_LA_W-1:0]   lo_q;
  logic [`TCD_LA_W-1:0]   lo_d;
  logic [1:0]             vw_q;
  logic [1:0]             vw_d;
  logic [4:0]             gap_q;
  logic [4:0]             gap_d;
  logic                   oe_s1_q;
  logic                   oe_s2_q;

  // link clock divider; fields change while link clock is low
  always_comb begin
    div_d  = div_q + 4'h1;
    lclk_d = lclk_q;
    edge_d = 1'b0;
    if (div_q == `TCD_DIV_HALF) begin
      div_d  = 4'h0;
      lclk_d = ~lclk_q;
      edge_d = lclk_q;
    end
  end

  // command sequencing, one pin update per link clock period
  always_comb begin
    st_d  = st_q;
    op_d  = op_q;
    csn_d = csn_q;
    fn_d  = fn_q;
    pdn_d = pdn_q;
    ba_d  = ba_q;
    a_d   = a_q;
    lo_d  = lo_q;
    vw_d  = vw_q;
    gap_d = gap_q;
    if (req_i && st_q == CS_IDLE) begin
      op_d = tcd_op_t'(req_op_i);
      ba_d = req_bank_i;
      a_d  = req_upper_i;
      lo_d = req_lower_i;
      vw_d = req_vw_i;
      st_d = CS_PDWAIT;
    end else if (st_q == CS_REFGAP) begin
      // hold off the next command so refreshes stay spaced apart
      gap_d = gap_q - 5'h1;
      if (gap_q == 5'h0) begin
        st_d = CS_IDLE;
      end
    end else if (edge_d) begin
      case (st_q)
        CS_PDWAIT: begin
          csn_d = 1'b0;
          if (op_q == TCD_OP_NONE) begin
            csn_d = 1'b1; // power-down entry needs deselect
            if (!oe_s2_q) begin
              pdn_d = 1'b0; // caller keeps banks idle
              st_d  = CS_LOWPWR;
            end
          end else begin
            fn_d = (op_q == TCD_OP_READ || op_q == TCD_OP_MODE_SET);
            st_d = CS_SECOND;
          end
        end
        CS_SECOND: begin
          csn_d = (op_q == TCD_OP_READ || op_q == TCD_OP_WRITE);
          if (op_q != TCD_OP_MODE_SET) begin // mode code keeps bank and address
            a_d = {vw_q, a_q[`TCD_ADDR_W-3:`TCD_LA_W], lo_q};
          end
          if (op_q == TCD_OP_SELF_REFRESH) begin
            pdn_d = 1'b0;
            st_d  = CS_LOWPWR;
          end else if (op_q == TCD_OP_REFRESH) begin
            gap_d = `TCD_REF_GAP;
            st_d  = CS_REFGAP;
          end else begin
            st_d = CS_IDLE;
          end
        end
        CS_LOWPWR: begin
          csn_d = 1'b1;
          if (wake_i) begin
            pdn_d = 1'b1;
            st_d  = CS_IDLE;
          end
        end
        default: csn_d = 1'b1;
      endcase
    end
    if ((st_q == CS_IDLE || st_q == CS_REFGAP) && edge_d) begin
      csn_d = 1'b1;
    end
  end

  // registers; output enable from the link crosses with two flops
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      div_q       <= 4'h0;
      lclk_q      <= 1'b0;
      st_q        <= CS_IDLE;
      op_q        <= TCD_OP_NONE;
      csn_q       <= 1'b1;
      fn_q        <= 1'b0;
      pdn_q       <= 1'b1;
      ba_q        <= '0;
      a_q         <= '0;
      lo_q        <= '0;
      vw_q        <= 2'h0;
      gap_q       <= '0;
      oe_s1_q     <= 1'b0;
      oe_s2_q     <= 1'b0;
      busy_o      <= 1'b0;
      read_seen_o <= 1'b0;
    end else begin
      div_q       <= div_d;
      lclk_q      <= lclk_d;
      st_q        <= st_d;
      op_q        <= op_d;
      csn_q       <= csn_d;
      fn_q        <= fn_d;
      pdn_q       <= pdn_d;
      ba_q        <= ba_d;
      a_q         <= a_d;
      lo_q        <= lo_d;
      vw_q        <= vw_d;
      gap_q       <= gap_d;
      oe_s1_q     <= link.dq_oe;
      oe_s2_q     <= oe_s1_q;
      busy_o      <= (st_d != CS_IDLE);
      read_seen_o <= oe_s2_q;
    end
  end

  assign link.link_clk = lclk_q;
  assign link.chip_select_n = csn_q;
  assign link.function_select = fn_q;
  assign link.bank = ba_q;
  assign link.addr = a_q;
  assign link.powerdown_pin_n = pdn_q; // held a full period around rise
endmodule

// ### tcd_device.sv
// memory-side command decoder clocked by the link clock
//
// Overview of operation
// - commands sampled on rising link clock
// - first command: deselect, read or write activate
// - second command follows activate on next clock
// - operation chosen from first/second command pair
// - mode set: read activate then chip-select low
// - top two address bits carry write length
// - write length decoded per burst length
// - self-refresh: pin low with second command of refresh pair
// - pin lowered only after outputs tristated; the controller waits for this before power-down only, not before self-refresh
// - pin rise with deselect exits asynchronously
// - read data edge-aligned with read strobe
// - lower strobe lanes 0-17, upper 18-35
// - power-down only while all banks idle
// - eight refreshes average over 400 ns
`timescale 1ns/1ps
`include "tcd_cfg.svh"
module tcd_device
  import tcd_pkg::*;
#(
  parameter int BURST_LEN = 4                       // 2 or 4
) (
  tcd_link_if.dev                 link,             // link pins
  input  wire logic               free_strobe_i,    // free-running strobe mode
  input  wire logic [`TCD_DQ_W-1:0] rd_data_i,      // data for read bursts
  output logic [2:0]              op_o,             // decoded operation
  output logic [`TCD_BA_W-1:0]    op_bank_o,        // bank of operation
  output logic [`TCD_ADDR_W-1:0]  op_upper_o,       // upper address
  output logic [`TCD_LA_W-1:0]    op_lower_o,       // lower address
  output logic [3:0]              write_mask_o,     // words written
  output logic                    write_reserved_o, // reserved length code
  output logic [`TCD_BA_W+`TCD_ADDR_W-1:0] mode_code_o, // mode op-code
  output logic                    powered_down_o,   // power-down or self-refresh
  output logic                    self_refresh_o    // self-refresh active
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACT_RD,
    ST_ACT_WR,
    ST_READ,
    ST_LOWPWR
  } tcd_dstate_t;

  wire clk = link.link_clk;                          // the device runs on the link clock

  // decoder state; there is no reset, so every path settles from unknown
  tcd_dstate_t                      st_q;
  tcd_dstate_t                      st_d;
  tcd_op_t                          op_q;
  tcd_op_t                          op_d;
  logic [`TCD_BA_W-1:0]             bank_q;
  logic [`TCD_BA_W-1:0]             bank_d;
  logic [`TCD_ADDR_W-1:0]           up_q;
  logic [`TCD_ADDR_W-1:0]           up_d;
  logic [`TCD_LA_W-1:0]             lo_q;
  logic [`TCD_LA_W-1:0]             lo_d;
  logic [3:0]                       wm_q;
  logic [3:0]                       wm_d;
  logic                             wres_q;
  logic                             wres_d;
  logic [`TCD_BA_W+`TCD_ADDR_W-1:0] mc_q;
  logic [`TCD_BA_W+`TCD_ADDR_W-1:0] mc_d;
  logic                             pd_prev_q;
  logic                             lp_q;
  logic                             lp_d;
  logic                             sr_q;
  logic                             sr_d;
  logic [1:0]                       rcnt_q;
  logic [1:0]                       rcnt_d;
  logic                             strobe_q;
  logic                             strobe_d;
  logic                             dq_oe_q;
  logic                             dq_oe_d;
  logic [`TCD_DQ_W-1:0]             dq_q;
  logic [`TCD_DQ_W-1:0]             dq_d;
  logic                             wake_q;
  logic                             wake_s1_q;
  logic                             wake_s2_q;
  logic                             free_s1_q;
  logic                             free_s2_q;

  // pin rise sets the wake flag with no clock; held clear while awake
  always_ff @(posedge link.powerdown_pin_n or negedge lp_q) begin
    if (!lp_q) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= 1'b1;
    end
  end

  // next state: command pair decode and low power tracking
  always_comb begin
    st_d   = st_q;
    op_d   = TCD_OP_NONE;
    bank_d = bank_q;
    up_d   = up_q;
    lo_d   = lo_q;
    wm_d   = wm_q;
    wres_d = wres_q;
    mc_d   = mc_q;
    lp_d   = lp_q;
    sr_d   = sr_q;
    case (st_q)
      ST_IDLE: begin
        if (pd_prev_q && !link.powerdown_pin_n && link.chip_select_n) begin
          st_d = ST_LOWPWR;
          lp_d = 1'b1;
          sr_d = 1'b0;
        end else if (!link.chip_select_n) begin
          bank_d = link.bank;
          up_d   = link.addr;
          if (link.function_select) begin
            st_d = ST_ACT_RD;
          end else begin
            st_d = ST_ACT_WR;
          end
        end
      end
      ST_ACT_RD: begin
        st_d = ST_IDLE;
        if (link.chip_select_n) begin
          op_d = TCD_OP_READ;
          lo_d = link.addr[`TCD_LA_W-1:0];
          st_d = ST_READ;
        end else begin
          op_d = TCD_OP_MODE_SET;
          mc_d = {link.bank, link.addr};
        end
      end
      ST_ACT_WR: begin
        st_d = ST_IDLE;
        if (link.chip_select_n) begin
          op_d   = TCD_OP_WRITE;
          lo_d   = link.addr[`TCD_LA_W-1:0];
          wres_d = 1'b0;
          if (BURST_LEN == 2) begin
            if (link.addr[`TCD_VW0_BIT]) begin
              wm_d = 4'h1;
            end else begin
              wm_d = 4'h3;
            end
          end else begin
            // burst of four: the length code picks how many words land
            case ({link.addr[`TCD_VW0_BIT], link.addr[`TCD_VW1_BIT]})
              2'b00: begin
                wm_d   = 4'h0;
                wres_d = 1'b1;
              end
              2'b10: wm_d = 4'hf;
              2'b01: wm_d = 4'h3;
              default: wm_d = 4'h1;
            endcase
          end
        end else if (!link.powerdown_pin_n) begin
          op_d = TCD_OP_SELF_REFRESH;
          st_d = ST_LOWPWR;
          lp_d = 1'b1;
          sr_d = 1'b1;
        end else begin
          op_d = TCD_OP_REFRESH;
        end
      end
      ST_READ: begin
        if (rcnt_q == 2'h0) begin
          st_d = ST_IDLE;
        end
      end
      ST_LOWPWR: begin
        // exit only once the wake flag has crossed and the pin still stands high
        if (wake_s2_q && link.powerdown_pin_n) begin
          st_d = ST_IDLE;
          lp_d = 1'b0;
          sr_d = 1'b0;
        end
      end
      default: begin
        st_d = ST_IDLE;
        lp_d = 1'b0;
        sr_d = 1'b0;
      end
    endcase
  end

  // read burst: strobe toggles each clock, data edge-aligned to strobe
  always_comb begin
    rcnt_d   = rcnt_q;
    dq_oe_d  = 1'b0;
    dq_d     = dq_q;
    strobe_d = 1'b0;
    if (free_s2_q) begin
      strobe_d = ~strobe_q;
    end
    if (st_d == ST_READ) begin
      if (st_q == ST_READ) begin
        rcnt_d = rcnt_q - 2'h1;
      end else begin
        rcnt_d = 2'(BURST_LEN - 1);
      end
      dq_oe_d  = 1'b1;
      dq_d     = rd_data_i;
      strobe_d = ~strobe_q;
    end
  end

  // state registers; wake flag and strobe mode pass two flops first
  always_ff @(posedge clk) begin
    st_q      <= st_d;
    op_q      <= op_d;
    bank_q    <= bank_d;
    up_q      <= up_d;
    lo_q      <= lo_d;
    wm_q      <= wm_d;
    wres_q    <= wres_d;
    mc_q      <= mc_d;
    lp_q      <= lp_d;
    sr_q      <= sr_d;
    pd_prev_q <= link.powerdown_pin_n;
    rcnt_q    <= rcnt_d;
    strobe_q  <= strobe_d;
    dq_oe_q   <= dq_oe_d;
    dq_q      <= dq_d;
    wake_s1_q <= wake_q;
    wake_s2_q <= wake_s1_q;
    free_s1_q <= free_strobe_i;
    free_s2_q <= free_s1_q;
  end

  // pins and user outputs
  assign link.dq = dq_q;
  assign link.dq_oe = dq_oe_q;
  assign link.lower_read_strobe = strobe_q; // lanes 0-17
  assign link.upper_read_strobe = strobe_q; // lanes 18-35
  assign op_o = op_q;
  assign op_bank_o = bank_q;
  assign op_upper_o = up_q;
  assign op_lower_o = lo_q;
  assign write_mask_o = wm_q;
  assign write_reserved_o = wres_q;
  assign mode_code_o = mc_q;
  assign powered_down_o = lp_q;
  assign self_refresh_o = sr_q;
endmodule

// ### tcd_link_if.sv
// link between controller and memory command front end
`timescale 1ns/1ps
`include "tcd_cfg.svh"
interface tcd_link_if;
  logic                      link_clk;
  logic                      chip_select_n;
  logic                      function_select;
  logic [`TCD_BA_W-1:0]      bank;
  logic [`TCD_ADDR_W-1:0]    addr;
  logic                      powerdown_pin_n;
  logic [`TCD_DQ_W-1:0]      dq;
  logic                      dq_oe;
  logic                      lower_read_strobe;
  logic                      upper_read_strobe;
  modport ctrl (output link_clk, chip_select_n, function_select, bank, addr, powerdown_pin_n,
                input dq, dq_oe, lower_read_strobe, upper_read_strobe);
  modport dev (input link_clk, chip_select_n, function_select, bank, addr, powerdown_pin_n,
               output dq, dq_oe, lower_read_strobe, upper_read_strobe);
endinterface

// ### tcd_link_monitor.sv
// concurrent checks on the link between controller and device
`timescale 1ns/1ps
module tcd_link_monitor (
  input wire logic link_clk,          // link clock
  input wire logic resetn_i,          // controller reset, active low
  input wire logic free_strobe_i,     // free-running strobe mode
  input wire logic chip_select_n,     // low selects the device
  input wire logic function_select,   // read or write activate
  input wire logic powerdown_pin_n,   // low puts the device to sleep
  input wire logic dq_oe,             // device drives the data lanes
  input wire logic lower_read_strobe, // strobe for lanes 0-17
  input wire logic upper_read_strobe  // strobe for lanes 18-35
);
  logic [2:0] warm_q;
  // the device has no reset; wait a few link clocks before checking it
  always_ff @(posedge link_clk or negedge resetn_i) begin
    if (!resetn_i) begin
      warm_q <= 3'h0;
    end else if (warm_q != 3'h7) begin
      warm_q <= warm_q + 3'h1;
    end
  end
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!resetn_i || warm_q != 3'h7);
  // a pair never keeps select low into a third link cycle
  pair_length_a: assert property ($fell(chip_select_n) |=> ##1 chip_select_n)
    else $error("select held past the second command");
  // read activate then address latch brings read data out
  read_burst_a: assert property ((!chip_select_n && function_select && $past(chip_select_n)) ##1 chip_select_n
    |-> ##[1:12] dq_oe) else $error("no read data after a read pair");
  // write activate then refresh drives no data for eight link cycles
  refresh_quiet_a: assert property ((!chip_select_n && !function_select && $past(chip_select_n))
    ##1 !chip_select_n |-> !dq_oe [*8]) else $error("data driven after a refresh pair");
  // plain strobe mode keeps strobes still outside read data
  quiet_strobe_a: assert property (!free_strobe_i && !dq_oe && !$past(dq_oe) && !$past(dq_oe, 2)
    |-> $stable(lower_read_strobe) && $stable(upper_read_strobe)) else $error("strobe moved with no read");
  // both strobe halves time their lanes together
  strobe_pair_a: assert property (lower_read_strobe == upper_read_strobe)
    else $error("lower and upper strobes differ");
  // sleep pin falls only with the data lanes released
  pd_tristate_a: assert property ($fell(powerdown_pin_n) |-> !dq_oe)
    else $error("sleep pin fell while data driven");
  // while asleep the controller keeps the device deselected
  pd_hold_a: assert property (!powerdown_pin_n && !$past(powerdown_pin_n) |-> chip_select_n)
    else $error("device selected while asleep");
  // wake-up happens only with select high
  pd_exit_a: assert property ($rose(powerdown_pin_n) |-> chip_select_n)
    else $error("sleep pin rose while selected");
endmodule

// ### tcd_pkg.sv
// shared types for the two-cycle command decoder
package tcd_pkg;
  typedef enum logic [2:0] {
    TCD_OP_NONE,
    TCD_OP_READ,
    TCD_OP_WRITE,
    TCD_OP_REFRESH,
    TCD_OP_MODE_SET,
    TCD_OP_SELF_REFRESH
  } tcd_op_t;
  typedef enum logic [1:0] {
    TCD_BL2,
    TCD_BL4
  } tcd_burst_t;
endpackage
